// File: rtl/rosc_pkg.sv
// constants and types shared by the remote output slave block
package rosc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // watchdog: four of the slowest cycle times of each mode
    localparam int HS_TIMEOUT_US = 3200;
    localparam int LD_TIMEOUT_US = 24000;
    localparam logic [7:0] HS_TIMEOUT_TICKS = 8'(HS_TIMEOUT_US*1000/TICK_NS);
    localparam logic [7:0] LD_TIMEOUT_TICKS = 8'(LD_TIMEOUT_US*1000/TICK_NS);

    // ****************************************
    // link rates in bits per second
    // ****************************************
    localparam logic [31:0] HS_BAUD_BPS = 32'd750000;
    localparam logic [31:0] LD_BAUD_BPS = 32'd93750;

    // ****************************************
    // widths
    // ****************************************
    localparam int OUT_W = 16;
    localparam int NODE_W = 4;
    localparam int ADDR_W = 8;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_BAUD = 8'h10;

    // status and mask bits
    localparam int EV_W = 3;
    localparam int EV_LINK_UP = 0;
    localparam int EV_LINK_OK_LAMP_ERR = 1;
    localparam int EV_MODE_MISMATCH = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // config field positions
    localparam int CFG_NODE_LSB = 0;
    localparam int CFG_HOLD_BIT = 4;
    localparam int CFG_LONG_BIT = 5;
    localparam int CFG_GEN2_BIT = 6;
    localparam int CFG_LONG_SW_BIT = 7;

    // state field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_OUT_LSB = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ROSC_STANDBY,
        ROSC_RUN,
        ROSC_FAULT
    } rosc_state_t;

endpackage

// File: rtl/rosc_tick_gen.sv
// divider that yields a one-cycle timebase enable
`timescale 1ns/10ps
`default_nettype none

module rosc_tick_gen #(
    parameter int TICK_CYCLES = rosc_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    output logic tick
);

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic tick_d;
    logic tick_q;

    always_comb begin
        tick_d = (cnt_q == TICK_LAST);
        cnt_d = tick_d ? 16'h0000 : cnt_q + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule
`default_nettype wire

// File: rtl/rosc_top.sv
// remote output slave: switch capture, link supervision, outputs, registers
`timescale 1ns/10ps
`default_nettype none

// Contract
// - On a link error outputs go OFF if hold is off, else keep their state.
// - Mode switch off runs high speed at 750 kbps, on runs 93.75 kbps.
// - The first-generation variant always runs high speed, switch ignored.
// - Slave and master must share one link mode, else no normal traffic.
// - Node number is the unsigned sum of switch weights 8, 4, 2, 1 (0-15).
// - Switches are taken at power-up; later changes wait for the next one.
// - Link-ok lamp only in normal traffic, error lamp on error, none idle.
// - In standby every output and its indicator stays OFF.
module rosc_top #(
    parameter int TICK_CYCLES = rosc_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    // switches and variant strap
    input wire logic hold_sw,
    input wire logic long_sw,
    input wire logic [rosc_pkg::NODE_W-1:0] node_sw,
    input wire logic gen2_strap,
    // frames decoded from the bus
    input wire logic frm_valid,
    input wire logic [rosc_pkg::NODE_W-1:0] frm_node,
    input wire logic frm_long,
    input wire logic [rosc_pkg::OUT_W-1:0] frm_data,
    input wire logic frm_bad,
    // drive, lamps and interrupt
    output logic [rosc_pkg::OUT_W-1:0] out_drive,
    output logic [rosc_pkg::OUT_W-1:0] out_lamp,
    output logic link_ok_lamp,
    output logic err_lamp,
    output logic irq,
    // axi4-lite slave
    input wire logic [rosc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rosc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // power-up capture of switches
    // ****************************************
    logic cap_done_q, cap_done_d;
    logic [rosc_pkg::NODE_W-1:0] node_q, node_d;
    logic hold_q, hold_d;
    logic long_q, long_d;
    logic long_sw_q, long_sw_d;
    logic gen2_q, gen2_d;
    always_comb begin
        cap_done_d = 1'b1;
        node_d = node_q;
        hold_d = hold_q;
        long_d = long_q;
        long_sw_d = long_sw_q;
        gen2_d = gen2_q;
        // taken once after release; later switch moves are not seen
        if (!cap_done_q) begin
            node_d = node_sw;
            hold_d = hold_sw;
            long_sw_d = long_sw;
            gen2_d = gen2_strap;
            long_d = gen2_strap & long_sw;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cap_done_q <= 1'b0;
            node_q <= 4'h0;
            hold_q <= 1'b0;
            long_q <= 1'b0;
            long_sw_q <= 1'b0;
            gen2_q <= 1'b0;
        end else begin
            cap_done_q <= cap_done_d;
            node_q <= node_d;
            hold_q <= hold_d;
            long_q <= long_d;
            long_sw_q <= long_sw_d;
            gen2_q <= gen2_d;
        end
    end

    // ****************************************
    // link supervision
    // ****************************************
    logic tick;
    rosc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick(tick)
    );
    rosc_pkg::rosc_state_t st_q, st_d;
    logic [rosc_pkg::OUT_W-1:0] out_q, out_d;
    logic [7:0] wd_q, wd_d;
    logic ok_q, ok_d;
    logic err_q, err_d;
    logic [rosc_pkg::EV_W-1:0] ev;
    logic for_me, good, wd_limit_hit;
    logic [7:0] wd_limit;
    always_comb begin
        for_me = cap_done_q && frm_valid && (frm_node == node_q);
        // a frame sent in the other mode is not normal traffic
        good = for_me && (frm_long == long_q);
        wd_limit = long_q ? rosc_pkg::LD_TIMEOUT_TICKS
                          : rosc_pkg::HS_TIMEOUT_TICKS;
        wd_limit_hit = (wd_q >= wd_limit);
        st_d = st_q;
        out_d = out_q;
        wd_d = wd_q;
        ev = '0;
        ev[rosc_pkg::EV_MODE_MISMATCH] = for_me && !good;
        case (st_q)
            rosc_pkg::ROSC_STANDBY: begin
                out_d = '0;
                wd_d = 8'h00;
                if (good) begin
                    st_d = rosc_pkg::ROSC_RUN;
                    out_d = frm_data;
                    ev[rosc_pkg::EV_LINK_UP] = 1'b1;
                end
            end
            rosc_pkg::ROSC_RUN: begin
                if (good) begin
                    out_d = frm_data;
                    wd_d = 8'h00;
                end else if (frm_bad || wd_limit_hit) begin
                    st_d = rosc_pkg::ROSC_FAULT;
                    out_d = hold_q ? out_q : '0;
                    wd_d = 8'h00;
                    ev[rosc_pkg::EV_LINK_OK_LAMP_ERR] = 1'b1;
                end else if (tick) begin
                    wd_d = wd_q + 8'h01;
                end
            end
            rosc_pkg::ROSC_FAULT: begin
                if (good) begin
                    st_d = rosc_pkg::ROSC_RUN;
                    out_d = frm_data;
                    ev[rosc_pkg::EV_LINK_UP] = 1'b1;
                end
            end
            default: begin
                st_d = rosc_pkg::ROSC_STANDBY;
                out_d = '0;
            end
        endcase
        ok_d = (st_d == rosc_pkg::ROSC_RUN);
        err_d = (st_d == rosc_pkg::ROSC_FAULT);
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= rosc_pkg::ROSC_STANDBY;
            out_q <= '0;
            wd_q <= 8'h00;
            ok_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            out_q <= out_d;
            wd_q <= wd_d;
            ok_q <= ok_d;
            err_q <= err_d;
        end
    end
    assign out_drive = out_q;
    // lamps mirror the drive register, so standby shows all dark
    assign out_lamp = out_q;
    assign link_ok_lamp = ok_q;
    assign err_lamp = err_q;
    // ****************************************
    // register slave
    // ****************************************
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [rosc_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [rosc_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic irq_q, irq_d;
    logic awready_q, wready_q, arready_q, awready_d, wready_d, arready_d;
    logic do_wr, do_rd;
    logic [rosc_pkg::EV_W-1:0] stat_clr;
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        mask_d = mask_q;
        stat_clr = '0;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        do_wr = aw_have_q && w_have_q && !bvalid_q;
        if (do_wr) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = rosc_pkg::RESP_OKAY;
            case (awaddr_q)
                rosc_pkg::REG_MASK: begin
                    if (wstrb_q[0]) begin
                        mask_d = wdata_q[rosc_pkg::EV_W-1:0];
                    end
                end
                rosc_pkg::REG_STATUS, rosc_pkg::REG_CONFIG,
                rosc_pkg::REG_STATE, rosc_pkg::REG_BAUD: begin
                end
                default: begin
                    bresp_d = rosc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        do_rd = s_axi_arvalid && arready_q;
        if (do_rd) begin
            rvalid_d = 1'b1;
            rresp_d = rosc_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case (s_axi_araddr)
                rosc_pkg::REG_STATUS: begin
                    rdata_d[rosc_pkg::EV_W-1:0] = stat_q;
                    stat_clr = stat_q;
                end
                rosc_pkg::REG_MASK: begin
                    rdata_d[rosc_pkg::EV_W-1:0] = mask_q;
                end
                rosc_pkg::REG_CONFIG: begin
                    rdata_d[rosc_pkg::CFG_NODE_LSB +: rosc_pkg::NODE_W] =
                        node_q;
                    rdata_d[rosc_pkg::CFG_HOLD_BIT] = hold_q;
                    rdata_d[rosc_pkg::CFG_LONG_BIT] = long_q;
                    rdata_d[rosc_pkg::CFG_GEN2_BIT] = gen2_q;
                    rdata_d[rosc_pkg::CFG_LONG_SW_BIT] = long_sw_q;
                end
                rosc_pkg::REG_STATE: begin
                    rdata_d[rosc_pkg::ST_STATE_LSB +: 2] = st_q;
                    rdata_d[rosc_pkg::ST_OUT_LSB +: rosc_pkg::OUT_W] = out_q;
                end
                rosc_pkg::REG_BAUD: begin
                    rdata_d = long_q ? rosc_pkg::LD_BAUD_BPS
                                     : rosc_pkg::HS_BAUD_BPS;
                end
                default: begin
                    rresp_d = rosc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // a new event wins over the clear by read
        stat_d = (stat_q & ~stat_clr) | ev;
        irq_d = |(stat_d & mask_d);
        // one write and one read in flight; ready drops once held
        awready_d = !aw_have_d && !(s_axi_awvalid && awready_q);
        wready_d = !w_have_d && !(s_axi_wvalid && wready_q);
        arready_d = !rvalid_d && !do_rd;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= rosc_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= rosc_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            stat_q <= '0;
            mask_q <= rosc_pkg::MASK_RESET;
            irq_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// File: bench/rosc_top_assertions.sv
// port-level checker for the remote output slave
`timescale 1ns/10ps
`default_nettype none
module rosc_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frm_valid,
    input wire logic frm_bad,
    input wire logic [rosc_pkg::OUT_W-1:0] out_drive,
    input wire logic [rosc_pkg::OUT_W-1:0] out_lamp,
    input wire logic link_ok_lamp,
    input wire logic err_lamp,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ****************************************
    // bus sequences
    // ****************************************
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ****************************************
    // properties
    // ****************************************
    property p_standby_off;
        !link_ok_lamp && !err_lamp |-> out_drive == '0;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("outputs on in standby");
    property p_lamp_follow;
        out_lamp == out_drive;
    endproperty
    a_lamp_follow: assert property (p_lamp_follow)
        else $error("output lamps differ from outputs");
    property p_lamps_excl;
        !(link_ok_lamp && err_lamp);
    endproperty
    a_lamps_excl: assert property (p_lamps_excl)
        else $error("both lamps lit");
    property p_bad_faults;
        frm_bad && link_ok_lamp |=> err_lamp && !link_ok_lamp;
    endproperty
    a_bad_faults: assert property (p_bad_faults)
        else $error("bad frame did not raise fault");
    property p_fault_outputs;
        $rose(err_lamp) |-> out_drive == '0 || $stable(out_drive);
    endproperty
    a_fault_outputs: assert property (p_fault_outputs)
        else $error("outputs neither cleared nor held on fault");
    property p_link_cause;
        $rose(link_ok_lamp) |-> $past(frm_valid);
    endproperty
    a_link_cause: assert property (p_link_cause)
        else $error("link lamp lit without a frame");
    property p_drive_cause;
        $changed(out_drive) |-> $past(frm_valid) || $rose(err_lamp);
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("outputs changed without cause");
    property p_wr_resp;
        s_wr_take |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_rd_resp;
        s_rd_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read data late");
    property p_rd_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rd_done: assert property (p_rd_done)
        else $error("read data held after handshake");
endmodule
bind rosc_top rosc_chk chk_u (.*);
`default_nettype wire

// File: bench/rosc_master_model.sv
// frame source standing in for the bus master unit
`timescale 1ns/10ps
`default_nettype none
module rosc_master_model (
    input wire logic ref_clk,
    output logic frm_valid,
    output logic [3:0] frm_node,
    output logic frm_long,
    output logic [15:0] frm_data,
    output logic frm_bad
);
    logic [3:0] n_q;
    logic l_q;
    logic [15:0] d_q;
    logic [15:0] idle_q = 16'h5A3C;
    initial begin
        frm_valid = 1'b0;
        frm_bad = 1'b0;
    end
    // idle lines churn so a stale frame can never look valid
    always @(posedge ref_clk) idle_q <= ~idle_q + 16'h1;
    assign frm_node = frm_valid ? n_q : idle_q[3:0];
    assign frm_long = frm_valid ? l_q : idle_q[4];
    assign frm_data = frm_valid ? d_q : idle_q;
    // node and mode as the bench commands, even unserved ones
    task automatic send(input logic [3:0] n, input logic l,
                        input logic [15:0] d);
        @(posedge ref_clk);
        n_q <= n;
        l_q <= l;
        d_q <= d;
        frm_valid <= 1'b1;
        @(posedge ref_clk);
        frm_valid <= 1'b0;
    endtask
    task automatic glitch;
        @(posedge ref_clk);
        frm_bad <= 1'b1;
        @(posedge ref_clk);
        frm_bad <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the remote output slave
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [3:0] n;
        logic l;
        logic [15:0] d;
        logic [15:0] e;
        logic ok;
    } rosc_row_t;
    localparam rosc_row_t ROWS [5] = '{
        '{4'h5, 1'b0, 16'hAAAA, 16'h0000, 1'b0},
        '{4'hA, 1'b1, 16'h5555, 16'h0000, 1'b0},
        '{4'hA, 1'b0, 16'h1234, 16'h1234, 1'b1},
        '{4'hA, 1'b0, 16'h0001, 16'h0001, 1'b1},
        '{4'hB, 1'b0, 16'hFFFF, 16'h0001, 1'b1}};
    logic ref_clk, reset, hold_sw, long_sw, gen2_strap;
    logic [3:0] node_sw, frm_node;
    logic frm_valid, frm_long, frm_bad, link_ok_lamp, err_lamp, irq;
    logic [15:0] frm_data, out_drive, out_lamp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int fails, tests_run;
    rosc_top #(.TICK_CYCLES(4)) dut_u (.*);
    rosc_master_model pm_u (.*);
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic power_up(input logic h, l, g, input logic [3:0] n);
        @(posedge ref_clk);
        reset <= 1'b1;
        hold_sw <= h;
        long_sw <= l;
        gen2_strap <= g;
        node_sw <= n;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        settle();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // generous: the run needs well under 3000 cycles
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        power_up(1'b0, 1'b0, 1'b1, 4'hA);
        chk(out_drive, 32'h0);
        chk({link_ok_lamp, err_lamp}, 32'h0);
        foreach (ROWS[i]) begin
            pm_u.send(ROWS[i].n, ROWS[i].l, ROWS[i].d);
            settle();
            chk(out_drive, ROWS[i].e);
            chk(link_ok_lamp, ROWS[i].ok);
        end
        axw(8'h04, 32'h7);
        chk(rs, rosc_pkg::RESP_OKAY);
        settle();
        chk(irq, 32'h1);
        axr(8'h04);
        chk(rd, 32'h7);
        axr(8'h00);
        chk(rd, 32'h5);
        settle();
        chk(irq, 32'h0);
        axr(8'h08);
        chk(rd, 32'h4A);
        axr(8'h10);
        chk(rd, rosc_pkg::HS_BAUD_BPS);
        axr(8'h14);
        chk(rs, rosc_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        axw(8'h14, 32'hFF);
        chk(rs, rosc_pkg::RESP_SLVERR);
        pm_u.glitch();
        settle();
        chk({link_ok_lamp, err_lamp, irq}, 32'h3);
        chk(out_drive, 32'h0);
        @(posedge ref_clk);
        node_sw <= 4'h3;
        hold_sw <= 1'b1;
        pm_u.send(4'hA, 1'b0, 16'h00C3);
        settle();
        chk({link_ok_lamp, out_drive}, 32'h1_00C3);
        pm_u.glitch();
        settle();
        chk(out_drive, 32'h0);
        power_up(1'b1, 1'b1, 1'b0, 4'h3);
        axr(8'h08);
        chk(rd, 32'h93);
        axr(8'h10);
        chk(rd, rosc_pkg::HS_BAUD_BPS);
        pm_u.send(4'h3, 1'b1, 16'h0F0F);
        settle();
        chk(out_drive, 32'h0);
        pm_u.send(4'h3, 1'b0, 16'h00F0);
        settle();
        chk(out_drive, 32'h00F0);
        repeat (200) @(posedge ref_clk);
        #1;
        chk({err_lamp, out_drive}, 32'h1_00F0);
        chk(out_lamp, 32'h00F0);
        axr(8'h0C);
        chk(rd, 32'h00F0_0002);
        power_up(1'b0, 1'b1, 1'b1, 4'h0);
        axr(8'h10);
        chk(rd, rosc_pkg::LD_BAUD_BPS);
        s_axi_wstrb <= 4'hE;
        axw(8'h04, 32'h7);
        s_axi_wstrb <= 4'hF;
        chk(rs, rosc_pkg::RESP_OKAY);
        axr(8'h04);
        chk(rd, 32'h0);
        pm_u.send(4'h0, 1'b1, 16'h8001);
        settle();
        chk({link_ok_lamp, out_drive}, 32'h1_8001);
        report_and_stop();
    end
endmodule
`default_nettype wire
